/* lpm_pkg.sv */
// Purpose: shared constants and types of the low-power mode supervisor
// Assumes: 32-bit register words at byte offsets, one system clock
// Notes:   register offsets are byte addresses on the plain register port
package lpm_pkg;

    localparam int PIN_N  = 4;   // dedicated wakeup-capable pins
    localparam int TAMP_N = 2;   // tamper inputs alive in battery mode
    localparam int PER_N  = 9;   // optional peripheral functions
    localparam int IRQ_N  = 9;   // sticky event bits
    localparam int SYNC_N = 2 + TAMP_N + PIN_N + 1;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_PER_EN   = 8'h04;
    localparam logic [7:0] OFF_WAKE     = 8'h08;
    localparam logic [7:0] OFF_IO_CFG   = 8'h0c;
    localparam logic [7:0] OFF_STATUS   = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

    // peripheral enable bit positions
    localparam int P_SERIAL = 0;
    localparam int P_I2C1   = 1;
    localparam int P_I2C2   = 2;
    localparam int P_I2C3   = 3;
    localparam int P_LPT1   = 4;
    localparam int P_LPT2   = 5;
    localparam int P_WDG    = 6;
    localparam int P_COMP   = 7;
    localparam int P_RNG    = 8;

    // sticky event bit positions
    localparam int IRQ_SERIAL = 0;
    localparam int IRQ_I2C    = 1;
    localparam int IRQ_LPTIM  = 2;
    localparam int IRQ_COMP   = 3;
    localparam int IRQ_WDG    = 4;
    localparam int IRQ_WKPIN  = 5;
    localparam int IRQ_RTC    = 6;
    localparam int IRQ_TAMPER = 7;
    localparam int IRQ_VBAT   = 8;

    // low-power target selection
    localparam logic [2:0] LPS_SLEEP = 3'h0;
    localparam logic [2:0] LPS_STOP0 = 3'h1;
    localparam logic [2:0] LPS_STOP1 = 3'h2;
    localparam logic [2:0] LPS_STOP2 = 3'h3;
    localparam logic [2:0] LPS_STBY  = 3'h4;
    localparam logic [2:0] LPS_SHDN  = 3'h5;

    // serial receiver wake event selection
    localparam logic [1:0] SER_START = 2'h0;
    localparam logic [1:0] SER_ADDR  = 2'h1;
    localparam logic [1:0] SER_FRAME = 2'h2;

    typedef struct packed {
        logic [1:0] serial_sel;
        logic       io_release;
        logic       hsi_on;
        logic       charge_en;
        logic       sram2_retain_bit;
        logic       vos_range1;
        logic       sram_gate;
        logic       flash_pd;
        logic       lprun;
        logic [2:0] lp_sel;
    } lpm_ctrl_t;

    typedef struct packed {
        logic [2*PIN_N-1:0] shdn_pull;
        logic [2*PIN_N-1:0] stby_pull;
    } lpm_io_cfg_t;

    typedef struct packed {
        logic [2:0] serial;  // start, address match, frame
        logic [2:0] i2c;     // address match per interface
        logic [1:0] lptim;
        logic       comp;
        logic       wdg;
    } lpm_evt_t;

    typedef enum logic [3:0] {
        ST_RUN, ST_LPRUN, ST_SLEEP, ST_LPSLEEP, ST_STOP0,
        ST_STOP1, ST_STOP2, ST_STBY, ST_SHDN, ST_VBAT
    } lpm_state_t;

    localparam lpm_ctrl_t   CTRL_RST = 13'h0040; // range 1 after reset
    localparam logic [PER_N-1:0] PER_RST = '0;
    localparam logic [2*PIN_N-1:0] WAKE_RST = '0;
    localparam lpm_io_cfg_t IO_RST   = '0;
    localparam logic [IRQ_N-1:0] IRQ_RST = '0;

endpackage : lpm_pkg

/* lpm_supervisor.sv */
// Purpose: low-power mode supervisor: gating, wakeup, retention, battery mode
// Assumes: pins and other-domain levels pass a two-flop synchroniser
// Notes:   registers on a plain port, read data one cycle after the strobe
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
module lpm_supervisor
    import lpm_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic [7:0]        addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [31:0]            rdata_o,
    input  wire logic              core_wfi_i,
    input  wire logic              core_irq_i,
    input  wire lpm_pkg::lpm_evt_t evt_i,
    input  wire logic [PER_N-1:0]  hsi_req_i,
    input  wire logic [PIN_N-1:0]  wakeup_pin_i,
    input  wire logic [TAMP_N-1:0] tamper_i,
    input  wire logic              rtc_evt_i,
    input  wire logic              vdd_ok_i,
    input  wire logic              rst_src_int_i,
    output lpm_pkg::lpm_state_t    state_o,
    output logic [PER_N-1:0]       per_en_o,
    output logic [PER_N-1:0]       hsi_feed_o,
    output logic                   hsi_on_o,
    output logic                   flash_pd_o,
    output logic                   sram_clk_en_o,
    output logic                   sram2_power_o,
    output logic                   charge_en_o,
    output logic                   msi4_sel_o,
    output logic                   io_analog_o,
    output logic                   io_pull_apply_o,
    output logic [2*PIN_N-1:0]     io_pull_o,
    output logic                   rst_pullup_o,
    output logic                   irq_o
);
    import lpm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // mode availability of each optional function
    function automatic logic avail(input lpm_state_t s, input int p, input logic r1);
        logic act;
        logic stop01;
        act    = (s == ST_RUN) || (s == ST_LPRUN) || (s == ST_SLEEP) || (s == ST_LPSLEEP);
        stop01 = (s == ST_STOP0) || (s == ST_STOP1);
        unique case (p)
            P_SERIAL, P_I2C3, P_LPT1, P_LPT2, P_COMP:
                avail = act || stop01 || (s == ST_STOP2);
            P_I2C1, P_I2C2: avail = act || stop01;
            P_WDG:  avail = act || stop01 || (s == ST_STOP2) || (s == ST_STBY);
            P_RNG:  avail = ((s == ST_RUN) || (s == ST_SLEEP)) && r1;
            default: avail = 1'b0;
        endcase
    endfunction : avail

    ////////////////////////////////////////////////////////////////////
    // synchronisers for pins and other-domain levels
    localparam logic [SYNC_N-1:0] SYNC_RST = {1'b1, {(SYNC_N-1){1'b0}}};
    logic [SYNC_N-1:0] sync1_q;
    logic [SYNC_N-1:0] sync2_q;
    logic [PIN_N-1:0]  pin_prev_q;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q    <= SYNC_RST;
            sync2_q    <= SYNC_RST;
            pin_prev_q <= '0;
        end else begin
            sync1_q    <= {vdd_ok_i, rst_src_int_i, tamper_i, wakeup_pin_i, rtc_evt_i};
            sync2_q    <= sync1_q;
            pin_prev_q <= sync2_q[PIN_N:1];
        end
    end

    wire logic              vdd_s = sync2_q[SYNC_N-1];
    wire logic              rsrc_s = sync2_q[SYNC_N-2];
    wire logic [TAMP_N-1:0] tamp_s = sync2_q[PIN_N+TAMP_N:PIN_N+1];
    wire logic [PIN_N-1:0]  pin_s = sync2_q[PIN_N:1];
    wire logic              rtc_s = sync2_q[0];

    ////////////////////////////////////////////////////////////////////
    // registers
    lpm_ctrl_t          ctrl_q;
    logic [PER_N-1:0]   per_q;
    logic [2*PIN_N-1:0] wake_q;   // [PIN_N-1:0] enable, upper half falling edge
    lpm_io_cfg_t        io_q;
    logic [IRQ_N-1:0]   stat_q;
    logic [IRQ_N-1:0]   mask_q;
    lpm_state_t         state_q;
    lpm_state_t         state_d;

    wire logic wr_ctrl = wr_i && (addr_i == OFF_CTRL);
    wire logic wr_per  = wr_i && (addr_i == OFF_PER_EN);
    wire logic wr_wake = wr_i && (addr_i == OFF_WAKE);
    wire logic wr_io   = wr_i && (addr_i == OFF_IO_CFG);
    wire logic wr_stat = wr_i && (addr_i == OFF_IRQ_STAT);
    wire logic wr_mask = wr_i && (addr_i == OFF_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////
    // wakeup sources
    wire logic [PIN_N-1:0] pin_rise = pin_s & ~pin_prev_q;
    wire logic [PIN_N-1:0] pin_fall = ~pin_s & pin_prev_q;
    wire logic [PIN_N-1:0] pin_edge = (wake_q[2*PIN_N-1:PIN_N] & pin_fall)
                                    | (~wake_q[2*PIN_N-1:PIN_N] & pin_rise);
    wire logic pin_wake = |(pin_edge & wake_q[PIN_N-1:0]);

    // serial receiver event chosen by configuration
    wire logic ser_evt = (ctrl_q.serial_sel == SER_START) ? evt_i.serial[0] :
                         (ctrl_q.serial_sel == SER_ADDR)  ? evt_i.serial[1] :
                         (ctrl_q.serial_sel == SER_FRAME) ? evt_i.serial[2] : 1'b0;

    // a function wakes only while enabled and available in the current mode
    logic [PER_N-1:0] live;
    always_comb begin
        for (int p = 0; p < PER_N; p++) begin
            live[p] = per_q[p] && avail(state_q, p, ctrl_q.vos_range1);
        end
    end

    wire logic w_ser  = live[P_SERIAL] && ser_evt;
    wire logic w_i2c  = |(live[P_I2C3:P_I2C1] & evt_i.i2c);
    wire logic w_lpt  = |(live[P_LPT2:P_LPT1] & evt_i.lptim);
    wire logic w_comp = live[P_COMP] && evt_i.comp;
    wire logic w_wdg  = live[P_WDG] && evt_i.wdg;
    wire logic w_rtc  = rtc_s || (|tamp_s);
    wire logic stop_wake = w_ser || w_i2c || w_lpt || w_comp || w_wdg || w_rtc;
    wire logic stby_wake = pin_wake || w_wdg || w_rtc;
    wire logic shdn_wake = pin_wake || w_rtc;
    wire logic in_stop   = (state_q == ST_STOP0) || (state_q == ST_STOP1)
                         || (state_q == ST_STOP2);
    wire logic run_state = state_q == (ctrl_q.lprun ? ST_LPRUN : ST_RUN);

    ////////////////////////////////////////////////////////////////////
    // power mode sequencing
    always_comb begin
        state_d = state_q;
        if (!vdd_s) begin
            state_d = ST_VBAT;
        end else begin
            unique case (state_q)
                ST_RUN, ST_LPRUN: begin
                    if (core_wfi_i) begin
                        unique case (ctrl_q.lp_sel)
                            LPS_STOP0: state_d = ST_STOP0;
                            LPS_STOP1: state_d = ST_STOP1;
                            LPS_STOP2: state_d = ST_STOP2;
                            LPS_STBY:  state_d = ST_STBY;
                            LPS_SHDN:  state_d = ST_SHDN;
                            default:   state_d = ctrl_q.lprun ? ST_LPSLEEP : ST_SLEEP;
                        endcase
                    end else begin
                        state_d = ctrl_q.lprun ? ST_LPRUN : ST_RUN;
                    end
                end
                ST_SLEEP:   if (core_irq_i) state_d = ST_RUN;
                ST_LPSLEEP: if (core_irq_i) state_d = ST_LPRUN;
                ST_STOP0, ST_STOP1, ST_STOP2: if (stop_wake) state_d = ST_RUN;
                ST_STBY:    if (stby_wake) state_d = ST_RUN;
                ST_SHDN:    if (shdn_wake) state_d = ST_RUN;
                ST_VBAT:    state_d = ST_RUN;  // only supply return leaves
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output decode
    wire logic sleepish = (state_q == ST_SLEEP) || (state_q == ST_LPSLEEP);
    wire logic awake    = run_state || (state_q == ST_RUN) || (state_q == ST_LPRUN);
    wire logic deep     = (state_q == ST_STBY) || (state_q == ST_SHDN) || (state_q == ST_VBAT);
    wire logic [PER_N-1:0] feed_d = in_stop ? (hsi_req_i & live) : '0;
    wire logic flash_pd_d = (awake || sleepish) ? ctrl_q.flash_pd : 1'b1;
    wire logic sram_clk_d = sleepish ? !ctrl_q.sram_gate : !deep;
    wire logic sram2_pw_d = (state_q == ST_STBY) ? ctrl_q.sram2_retain_bit
                                                 : !deep;
    wire logic apply_d    = (state_q == ST_STBY) || (state_q == ST_SHDN);
    wire logic [2*PIN_N-1:0] pull_d = (state_q == ST_STBY) ? io_q.stby_pull :
                                      (state_q == ST_SHDN) ? io_q.shdn_pull : '0;
    wire logic shdn_exit  = (state_q == ST_SHDN) && (state_d != ST_SHDN);

    // sticky event sources
    logic [IRQ_N-1:0] ev;
    always_comb begin
        ev             = '0;
        ev[IRQ_SERIAL] = w_ser;
        ev[IRQ_I2C]    = w_i2c;
        ev[IRQ_LPTIM]  = w_lpt;
        ev[IRQ_COMP]   = w_comp;
        ev[IRQ_WDG]    = w_wdg;
        ev[IRQ_WKPIN]  = pin_wake && deep;
        ev[IRQ_RTC]    = rtc_s;
        ev[IRQ_TAMPER] = |tamp_s;
        ev[IRQ_VBAT]   = (state_d == ST_VBAT) && (state_q != ST_VBAT);
    end
    wire logic [IRQ_N-1:0] stat_d = ev | (stat_q & ~(wr_stat ? wdata_i[IRQ_N-1:0] : '0));

    // read mux
    logic [31:0] rd_d;
    always_comb begin
        unique case (addr_i)
            OFF_CTRL:     rd_d = 32'(ctrl_q);
            OFF_PER_EN:   rd_d = 32'(per_q);
            OFF_WAKE:     rd_d = 32'(wake_q);
            OFF_IO_CFG:   rd_d = 32'(io_q);
            OFF_STATUS:   rd_d = {26'h0, vdd_s, rsrc_s, state_q};
            OFF_IRQ_STAT: rd_d = 32'(stat_q);
            OFF_IRQ_MASK: rd_d = 32'(mask_q);
            default:      rd_d = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CTRL_RST;
            per_q  <= PER_RST;
            wake_q <= WAKE_RST;
            io_q   <= IO_RST;
            stat_q <= IRQ_RST;
            mask_q <= IRQ_RST;
        end else begin
            if (wr_ctrl) ctrl_q <= lpm_ctrl_t'(wdata_i[12:0]);
            if (wr_per)  per_q  <= wdata_i[PER_N-1:0];
            if (wr_wake) wake_q <= wdata_i[2*PIN_N-1:0];
            if (wr_mask) mask_q <= wdata_i[IRQ_N-1:0];
            if (shdn_exit) begin
                io_q.shdn_pull <= '0;
            end else if (wr_io) begin
                io_q <= lpm_io_cfg_t'(wdata_i[4*PIN_N-1:0]);
            end
            stat_q <= stat_d;  // a new event wins over a clear
        end
    end

    // state and registered outputs
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q         <= ST_RUN;
            per_en_o        <= '0;
            hsi_feed_o      <= '0;
            hsi_on_o        <= 1'b0;
            flash_pd_o      <= 1'b0;
            sram_clk_en_o   <= 1'b1;
            sram2_power_o   <= 1'b1;
            charge_en_o     <= 1'b0;
            msi4_sel_o      <= 1'b1;
            io_analog_o     <= 1'b1;
            io_pull_apply_o <= 1'b0;
            io_pull_o       <= '0;
            rst_pullup_o    <= 1'b1;
            irq_o           <= 1'b0;
            rdata_o         <= 32'h0;
        end else begin
            state_q         <= state_d;
            per_en_o        <= live;
            hsi_feed_o      <= feed_d;
            hsi_on_o        <= (|feed_d) || (awake && ctrl_q.hsi_on);
            flash_pd_o      <= flash_pd_d;
            sram_clk_en_o   <= sram_clk_d;
            sram2_power_o   <= sram2_pw_d;
            charge_en_o     <= ctrl_q.charge_en && vdd_s;
            msi4_sel_o      <= shdn_exit || (msi4_sel_o && !wr_ctrl);
            io_analog_o     <= !ctrl_q.io_release;
            io_pull_apply_o <= apply_d;
            io_pull_o       <= pull_d;
            rst_pullup_o    <= !rsrc_s;
            irq_o           <= |(stat_d & mask_q);
            rdata_o         <= rd_i ? rd_d : 32'h0;
        end
    end
    assign state_o = state_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_supply_lost;
        !vdd_s && (state_q != ST_VBAT);
    endsequence

    a_rng_range_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        per_en_o[P_RNG] |-> $past(ctrl_q.vos_range1)
            && (($past(state_q) == ST_RUN) || ($past(state_q) == ST_SLEEP)))
        else $error("random generator enabled outside run or sleep range 1");
    a_sram2_retain: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_q == ST_STBY) |=> (sram2_power_o == $past(ctrl_q.sram2_retain_bit)))
        else $error("second bank power does not follow retain bit in standby");
    a_hsi_feed_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (in_stop && !hsi_req_i[P_SERIAL]) |=> !hsi_feed_o[P_SERIAL])
        else $error("oscillator still fed after request withdrawn");
    a_vbat_entry: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_supply_lost |=> (state_q == ST_VBAT) && (irq_o || !$past(mask_q[IRQ_VBAT])))
        else $error("battery mode not entered on supply loss");
    a_vbat_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((state_q == ST_VBAT) && !vdd_s) |=> (state_q == ST_VBAT))
        else $error("battery mode left without supply");
    a_charge_gate: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        charge_en_o |-> $past(vdd_s) && $past(ctrl_q.charge_en))
        else $error("charger enabled without supply");
    a_shdn_cfg_lost: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        shdn_exit |=> (io_q.shdn_pull == '0) && msi4_sel_o)
        else $error("shutdown pull setting survived exit");
    a_pullup_src: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(rsrc_s) |=> !rst_pullup_o)
        else $error("reset pull-up kept for internal reset");
    a_stby_wake_pin: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((state_q == ST_STBY) && vdd_s && !pin_wake && !w_wdg && !w_rtc)
            |=> (state_q == ST_STBY))
        else $error("standby left without a permitted source");
    a_i2c_stop2: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_q == ST_STOP2) |=> !per_en_o[P_I2C1] && !per_en_o[P_I2C2])
        else $error("two-wire interface 1 or 2 live in stop 2");

    // deep modes keep the flash powered down and shutdown drops every function
    a_flash_pd_deep: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (in_stop || deep) |=> flash_pd_o)
        else $error("flash not powered down in a deep mode");
    a_shdn_funcs_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_q == ST_SHDN) |=> (per_en_o == '0))
        else $error("optional function still enabled in shutdown");

    // the oscillator only ever reaches a peripheral that asked for it
    a_feed_only_req: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (hsi_feed_o & ~$past(hsi_req_i)) == '0)
        else $error("oscillator fed to a peripheral without a request");

    // serial receiver and third two-wire interface stay live in stop 2
    a_rx_stop2_live: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((state_q == ST_STOP2) && per_q[P_SERIAL]) |=> per_en_o[P_SERIAL])
        else $error("serial receiver not live in stop 2");
    a_i2c3_stop2: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((state_q == ST_STOP2) && per_q[P_I2C3]) |=> per_en_o[P_I2C3])
        else $error("third two-wire interface not live in stop 2");

    // the generator is never live in the low-power run and sleep modes
    a_rng_lp_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ((state_q == ST_LPRUN) || (state_q == ST_LPSLEEP)) |=> !per_en_o[P_RNG])
        else $error("random generator live in a low-power mode");

    // shutdown is left only through a pin edge, a clock or tamper event or lost supply
    sequence s_shdn_quiet;
        (state_q == ST_SHDN) && vdd_s && !pin_wake && !w_rtc;
    endsequence

    a_shdn_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_shdn_quiet |=> (state_q == ST_SHDN))
        else $error("shutdown left without a permitted source");

    // pads stay analog until software releases them
    a_io_analog_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        io_analog_o == !$past(ctrl_q.io_release))
        else $error("io analog state does not follow release bit");

endmodule : lpm_supervisor

/* lpm_supervisor_test.sv */
// Purpose: self-checking bench for the low-power mode supervisor
// Assumes: register port with read data one cycle after the read strobe
// Notes:   every scenario is its own task that drives and judges
`timescale 1ns/1ps
module lpm_supervisor_test;
    import lpm_pkg::*;
    logic              clock_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic              core_wfi_i = 1'b0, core_irq_i = 1'b0, rtc_evt_i = 1'b0;
    logic              vdd_ok_i = 1'b1, rst_src_int_i = 1'b0;
    logic [7:0]        addr_i = 8'h00;
    logic [31:0]       wdata_i = 32'h0, rdata_o;
    lpm_evt_t          evt_i = '0;
    logic [PER_N-1:0]  hsi_req_i = '0, per_en_o, hsi_feed_o;
    logic [PIN_N-1:0]  wakeup_pin_i = '0;
    logic [TAMP_N-1:0] tamper_i = '0;
    lpm_state_t        state_o;
    logic              hsi_on_o, flash_pd_o, sram_clk_en_o, sram2_power_o, charge_en_o;
    logic              msi4_sel_o, io_analog_o, io_pull_apply_o, rst_pullup_o, irq_o;
    logic [2*PIN_N-1:0] io_pull_o;
    int                n_errors = 0, tests_run = 0;
    // free-running system clock
    always #5 clock_i = ~clock_i;
    lpm_supervisor uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .core_wfi_i(core_wfi_i), .core_irq_i(core_irq_i), .evt_i(evt_i),
        .hsi_req_i(hsi_req_i), .wakeup_pin_i(wakeup_pin_i), .tamper_i(tamper_i),
        .rtc_evt_i(rtc_evt_i), .vdd_ok_i(vdd_ok_i), .rst_src_int_i(rst_src_int_i),
        .state_o(state_o), .per_en_o(per_en_o), .hsi_feed_o(hsi_feed_o),
        .hsi_on_o(hsi_on_o), .flash_pd_o(flash_pd_o), .sram_clk_en_o(sram_clk_en_o),
        .sram2_power_o(sram2_power_o), .charge_en_o(charge_en_o),
        .msi4_sel_o(msi4_sel_o), .io_analog_o(io_analog_o),
        .io_pull_apply_o(io_pull_apply_o), .io_pull_o(io_pull_o),
        .rst_pullup_o(rst_pullup_o), .irq_o(irq_o));
    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers: compare, wait, bus cycles
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cyc
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    // bounded wait for a mode, then let the dependent outputs settle
    task automatic wait_st(input lpm_state_t s);
        for (int i = 0; i < 100 && state_o !== s; i++) cyc(1);
        chk(32'(state_o), 32'(s));
        if (state_o !== s)
            test_done();
        cyc(2);
    endtask : wait_st
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd
    // program a target mode and let the core request low power
    task automatic enter(input logic [31:0] ctrl, input lpm_state_t s);
        wr(OFF_CTRL, ctrl);
        @(posedge clock_i);
        core_wfi_i <= 1'b1;
        @(posedge clock_i);
        core_wfi_i <= 1'b0;
        wait_st(s);
    endtask : enter
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        chk(32'(per_en_o), 32'h0);
        chk(32'(flash_pd_o), 32'h0);
        chk(32'(io_analog_o), 32'h1);
        chk(32'(rst_pullup_o), 32'h1);
        rd(OFF_CTRL, 32'h40);
        rd(8'h1c, 32'h0);
        @(posedge clock_i);
        rst_src_int_i <= 1'b1;
        cyc(6);
        chk(32'(rst_pullup_o), 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_rng();
        wr(OFF_PER_EN, 32'h10b);
        cyc(3);
        chk(32'(per_en_o), 32'h10b);
        wr(OFF_CTRL, 32'h10);
        cyc(3);
        chk(32'(flash_pd_o), 32'h1);
        chk(32'(per_en_o[P_RNG]), 32'h0);
        wr(OFF_CTRL, 32'h48);
        wait_st(ST_LPRUN);
        chk(32'(per_en_o[P_RNG]), 32'h0);
        wr(OFF_CTRL, 32'h40);
        wait_st(ST_RUN);
        $display("generator test done");
    endtask : t_rng
    task automatic t_sleep();
        enter(32'h60, ST_SLEEP);
        chk(32'(sram_clk_en_o), 32'h0);
        @(posedge clock_i);
        core_irq_i <= 1'b1;
        @(posedge clock_i);
        core_irq_i <= 1'b0;
        wait_st(ST_RUN);
        chk(32'(sram_clk_en_o), 32'h1);
        $display("sleep test done");
    endtask : t_sleep
    task automatic t_stop();
        wr(OFF_IRQ_MASK, 32'h1ff);
        enter(32'h43, ST_STOP2);
        chk(32'(per_en_o), 32'h009);
        @(posedge clock_i);
        hsi_req_i <= 9'h001;
        evt_i.i2c <= 3'b001;
        cyc(4);
        chk(32'(hsi_on_o), 32'h1);
        chk(32'(hsi_feed_o), 32'h1);
        chk(32'(state_o), 32'(ST_STOP2));
        @(posedge clock_i);
        hsi_req_i <= '0;
        evt_i     <= '0;
        cyc(4);
        chk(32'(hsi_on_o), 32'h0);
        @(posedge clock_i);
        evt_i.serial <= 3'b001;
        @(posedge clock_i);
        evt_i <= '0;
        wait_st(ST_RUN);
        chk(32'(irq_o), 32'h1);
        rd(OFF_IRQ_STAT, 32'h1);
        wr(OFF_IRQ_STAT, 32'h1);
        cyc(2);
        chk(32'(irq_o), 32'h0);
        $display("stop test done");
    endtask : t_stop
    task automatic t_vbat();
        wr(OFF_CTRL, 32'h140);
        cyc(3);
        chk(32'(charge_en_o), 32'h1);
        @(posedge clock_i);
        vdd_ok_i <= 1'b0;
        wait_st(ST_VBAT);
        chk(32'(charge_en_o), 32'h0);
        @(posedge clock_i);
        rtc_evt_i <= 1'b1;
        tamper_i  <= 2'b01;
        cyc(8);
        chk(32'(state_o), 32'(ST_VBAT));
        rd(OFF_IRQ_STAT, 32'h1c0);
        @(posedge clock_i);
        rtc_evt_i <= 1'b0;
        tamper_i  <= 2'b00;
        vdd_ok_i  <= 1'b1;
        wait_st(ST_RUN);
        wr(OFF_IRQ_STAT, 32'h1ff);
        $display("battery test done");
    endtask : t_vbat
    task automatic t_shdn();
        wr(OFF_WAKE, 32'h1);
        wr(OFF_IO_CFG, 32'h1200);
        enter(32'h45, ST_SHDN);
        chk(32'(io_pull_apply_o), 32'h1);
        chk(32'(io_pull_o), 32'h12);
        @(posedge clock_i);
        wakeup_pin_i <= 4'b0010;
        cyc(8);
        chk(32'(state_o), 32'(ST_SHDN));
        @(posedge clock_i);
        wakeup_pin_i <= 4'b0011;
        wait_st(ST_RUN);
        chk(32'(msi4_sel_o), 32'h1);
        rd(OFF_IO_CFG, 32'h0);
        @(posedge clock_i);
        wakeup_pin_i <= 4'b0000;
        enter(32'h44, ST_STBY);
        chk(32'(sram2_power_o), 32'h0);
        @(posedge clock_i);
        wakeup_pin_i <= 4'b0001;
        wait_st(ST_RUN);
        $display("shutdown test done");
    endtask : t_shdn
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: reset for six cycles, then every scenario
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        cyc(2);
        t_reset();
        t_rng();
        t_sleep();
        t_stop();
        t_vbat();
        t_shdn();
        test_done();
    end
endmodule : lpm_supervisor_test
